// ==== logic/swd_system_watchdog.sv ====
// Contract
// - interval programmable 1 to 255 seconds in one-second steps
// - armed watchdog resets system when interval elapses without refresh or disable
// - armed at boot, it resets the system if the os never takes control
// - usable at boot and at runtime; arm, refresh, disable by any software path
`include "swd_map.svh"
`default_nettype none
module swd_system_watchdog #(
  parameter int TICK_CYCLES = `SWD_TICK_CYCLES,
  parameter int RESET_PULSE_CYCLES = `SWD_RESET_PULSE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // software control, one-cycle pulses from same-clock logic
  input wire logic arm,
  input wire logic refresh,
  input wire logic disarm,
  input wire swd_pkg::swd_interval_t interval,
  // status and system reset
  output logic armed,
  output swd_pkg::swd_interval_t seconds_left,
  output logic sys_reset
);
  import swd_pkg::*;

  // a zero count would leave the prescaler or the pulse without an end
  if (TICK_CYCLES < 1 || RESET_PULSE_CYCLES < 1) begin : g_bad_counts
    $error("swd: counts must be at least one");
  end

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int PW = $clog2(RESET_PULSE_CYCLES + 1);
  localparam int LW = PW + 1;

  swd_state_t state_ff;
  swd_interval_t secs_ff;
  swd_interval_t load_val;
  logic [TW-1:0] tick_cnt_ff;
  logic [PW-1:0] pulse_cnt_ff;
  logic tick;
  logic armed_ff;
  logic sys_reset_ff;
  logic [LW-1:0] rst_len_ff;

  // zero would mean instant reset, so it is raised to the least step
  assign load_val = (interval < `SWD_INTERVAL_MIN) ? `SWD_INTERVAL_MIN : interval;
  assign tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));

  // tick prescaler restarts on arm and refresh so a full second is always granted
  always_ff @(posedge clk) begin
    if (!rst_n || state_ff != SWD_RUN || arm || refresh) begin
      tick_cnt_ff <= '0;
    end else if (tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TW'(1);
    end
  end

  // disable beats refresh and arm when they coincide; refresh and arm reload alike, and arm is taken in idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= SWD_IDLE;
      secs_ff <= `SWD_INTERVAL_RESET;
      pulse_cnt_ff <= '0;
    end else begin
      case (state_ff)
        SWD_IDLE: begin
          if (arm && !disarm) begin
            state_ff <= SWD_RUN;
            secs_ff <= load_val;
          end
        end
        SWD_RUN: begin
          if (disarm) begin
            state_ff <= SWD_IDLE;
          end else if (refresh || arm) begin
            secs_ff <= load_val;
          end else if (tick) begin
            if (secs_ff == 8'h01) begin
              state_ff <= SWD_FIRE;
              pulse_cnt_ff <= PW'(RESET_PULSE_CYCLES);
              secs_ff <= 8'h00;
            end else begin
              secs_ff <= secs_ff - 8'h01;
            end
          end
        end
        SWD_FIRE: begin
          // the reset pulse cannot be cancelled once started
          if (pulse_cnt_ff == PW'(1)) begin
            state_ff <= SWD_IDLE;
          end
          pulse_cnt_ff <= pulse_cnt_ff - PW'(1);
        end
        default: state_ff <= SWD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed_ff <= 1'b0;
      sys_reset_ff <= 1'b0;
    end else begin
      armed_ff <= (state_ff == SWD_RUN);
      sys_reset_ff <= (state_ff == SWD_FIRE);
    end
  end

  assign armed = armed_ff;
  assign sys_reset = sys_reset_ff;

  // pulse length is counted here, a long repetition would be too slow to check
  always_ff @(posedge clk) begin
    if (!rst_n || !sys_reset_ff) begin
      rst_len_ff <= '0;
    end else begin
      rst_len_ff <= rst_len_ff + LW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seconds_left <= `SWD_SECONDS_LEFT_RESET;
    end else begin
      seconds_left <= secs_ff;
    end
  end

  property p_fire_on_expiry;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_RUN && tick && secs_ff == 8'h01 && !disarm && !refresh && !arm)
      |=> state_ff == SWD_FIRE ##1 sys_reset;
  endproperty
  a_fire_on_expiry: assert property (p_fire_on_expiry) else $error("no reset at expiry");

  property p_disarm_no_reset;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_RUN && disarm) |=> state_ff == SWD_IDLE ##1 !sys_reset;
  endproperty
  a_disarm_no_reset: assert property (p_disarm_no_reset) else $error("disable failed");

  property p_refresh_reload;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_RUN && refresh && !disarm) |=> secs_ff == $past(load_val);
  endproperty
  a_refresh_reload: assert property (p_refresh_reload) else $error("refresh no reload");

  property p_arm_load;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_IDLE && arm && !disarm) |=> state_ff == SWD_RUN ##1 armed;
  endproperty
  a_arm_load: assert property (p_arm_load) else $error("arm not taken");

  property p_range;
    @(posedge clk) disable iff (!rst_n)
    state_ff == SWD_RUN |-> secs_ff >= `SWD_INTERVAL_MIN;
  endproperty
  a_range: assert property (p_range) else $error("count out of range");

  property p_reset_only_fire;
    @(posedge clk) disable iff (!rst_n)
    $rose(sys_reset) |-> $past(state_ff) == SWD_FIRE && $past(secs_ff) == 8'h00;
  endproperty
  a_reset_only_fire: assert property (p_reset_only_fire) else $error("spurious reset");

  property p_step_one;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_RUN && tick && !arm && !refresh && !disarm && secs_ff > 8'h01)
      |=> secs_ff == $past(secs_ff) - 8'h01;
  endproperty
  a_step_one: assert property (p_step_one) else $error("step not one second");

  property p_hold_between_ticks;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_RUN && !tick && !arm && !refresh && !disarm) |=> $stable(secs_ff);
  endproperty
  a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("count moved");

  property p_pulse_len;
    @(posedge clk) disable iff (!rst_n)
    $fell(sys_reset) |-> rst_len_ff == LW'(RESET_PULSE_CYCLES);
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse length wrong");

  property p_fire_holds;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_FIRE && pulse_cnt_ff != PW'(1)) |=> state_ff == SWD_FIRE;
  endproperty
  a_fire_holds: assert property (p_fire_holds) else $error("reset pulse cut short");

  property p_fire_from_run;
    @(posedge clk) disable iff (!rst_n)
    $rose(state_ff == SWD_FIRE) |-> $past(state_ff) == SWD_RUN && $past(tick);
  endproperty
  a_fire_from_run: assert property (p_fire_from_run) else $error("fire without expiry");

  // refresh alone must never start a countdown
  property p_idle_holds;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_IDLE && !arm) |=> state_ff == SWD_IDLE;
  endproperty
  a_idle_holds: assert property (p_idle_holds) else $error("left idle without arm");

  property p_rearm_reload;
    @(posedge clk) disable iff (!rst_n)
    (state_ff == SWD_RUN && arm && !disarm) |=> secs_ff == $past(load_val);
  endproperty
  a_rearm_reload: assert property (p_rearm_reload) else $error("re-arm no reload");

  property p_armed_tracks;
    @(posedge clk) disable iff (!rst_n)
    1'b1 |=> armed == $past(state_ff == SWD_RUN);
  endproperty
  a_armed_tracks: assert property (p_armed_tracks) else $error("armed flag wrong");

  c_fire: cover property (@(posedge clk) disable iff (!rst_n) $rose(sys_reset));
  c_refresh: cover property (@(posedge clk) disable iff (!rst_n) state_ff == SWD_RUN && refresh);
  c_disarm: cover property (@(posedge clk) disable iff (!rst_n) state_ff == SWD_RUN && disarm);
  c_rearm: cover property (@(posedge clk) disable iff (!rst_n) state_ff == SWD_RUN && arm);
  c_zero_iv: cover property (@(posedge clk) disable iff (!rst_n) arm && interval == 8'h00);
endmodule
`default_nettype wire

// ==== common/swd_map.svh ====
`ifndef SWD_MAP_SVH
`define SWD_MAP_SVH
`define SWD_TICK_NS 1000000000
`define SWD_CLK_NS 10
`define SWD_TICK_CYCLES (`SWD_TICK_NS / `SWD_CLK_NS)
`define SWD_INTERVAL_MIN 8'h01
`define SWD_INTERVAL_MAX 8'hff
`define SWD_INTERVAL_RESET 8'h01
`define SWD_RESET_PULSE_CYCLES 16
`define SWD_SECONDS_LEFT_RESET 8'h00
`endif

// ==== common/swd_pkg.sv ====
`default_nettype none
package swd_pkg;
  typedef enum logic [1:0] {
    SWD_IDLE = 2'b00,
    SWD_RUN = 2'b01,
    SWD_FIRE = 2'b11
  } swd_state_t;
  typedef logic [7:0] swd_interval_t;
endpackage
`default_nettype wire

// ==== tb/swd_system_watchdog_test.sv ====
`default_nettype none
module swd_system_watchdog_test;
  timeunit 1ns;
  timeprecision 1ps;
  import swd_pkg::*;
  // short prescale keeps the full 255 s row inside the run
  localparam int T = 10;
  localparam int P = 16;
  typedef struct {swd_interval_t iv; swd_interval_t secs;} swd_row_t;
  logic clk, rst_n, arm, refresh, disarm, armed, sys_reset;
  swd_interval_t interval, seconds_left;
  int fails = 0, samples_checked = 0, cyc = 0, k;
  swd_row_t rows[4] = '{'{8'h01, 8'h01}, '{8'h00, 8'h01}, '{8'h03, 8'h03}, '{8'hff, 8'hff}};
  swd_system_watchdog #(.TICK_CYCLES(T), .RESET_PULSE_CYCLES(P)) dut_u (
    .clk(clk), .rst_n(rst_n), .arm(arm), .refresh(refresh), .disarm(disarm),
    .interval(interval), .armed(armed), .seconds_left(seconds_left), .sys_reset(sys_reset));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic pulse(logic a, logic r, logic d, swd_interval_t iv);
    @(negedge clk);
    {arm, refresh, disarm, interval} = {a, r, d, iv};
    @(negedge clk);
    {arm, refresh, disarm} = 3'b000;
  endtask
  task automatic wait_fire(int lim, output int n);
    n = 0;
    while (sys_reset !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  // sys_reset shows two cycles after the last tick; lead cycles have already gone by
  task automatic fire_check(int s, int lead);
    int w;
    wait_fire(3000, k);
    chk("fire_time", 16'(k), 16'(s * T + 2 - lead));
    w = 0;
    while (sys_reset === 1'b1 && w < 40) begin
      @(negedge clk);
      w++;
    end
    chk("pulse_len", 16'(w), 16'(P));
    chk("armed_after", 16'(armed), 16'h0000);
    chk("secs_fired", 16'(seconds_left), 16'h0000);
  endtask
  task automatic results();
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rst_n, arm, refresh, disarm, interval} = {4'h0, 8'h01};
    repeat (12) @(negedge clk);
    chk("rst_out", 16'({armed, sys_reset, seconds_left}), 16'h0000);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      pulse(1'b1, 1'b0, 1'b0, rows[i].iv);
      repeat (2) @(negedge clk);
      chk("armed", 16'(armed), 16'h0001);
      chk("secs", 16'(seconds_left), 16'(rows[i].secs));
      fire_check(int'(rows[i].secs), 3);
    end
    pulse(1'b0, 1'b1, 1'b0, 8'h05);
    repeat (3) @(negedge clk);
    chk("idle_refresh", 16'(armed), 16'h0000);
    chk("idle_secs", 16'(seconds_left), 16'h0000);
    // refresh and re-arm land with one second left and must reload the full count
    pulse(1'b1, 1'b0, 1'b0, 8'h02);
    repeat (T + 5) @(negedge clk);
    chk("one_left", 16'(seconds_left), 16'h0001);
    pulse(1'b0, 1'b1, 1'b0, 8'h02);
    fire_check(2, 1);
    pulse(1'b1, 1'b0, 1'b0, 8'h02);
    repeat (T + 5) @(negedge clk);
    pulse(1'b1, 1'b0, 1'b0, 8'h03);
    fire_check(3, 1);
    pulse(1'b1, 1'b0, 1'b0, 8'h02);
    repeat (T) @(negedge clk);
    pulse(1'b0, 1'b0, 1'b1, 8'h00);
    wait_fire(3 * T, k);
    chk("disarm_quiet", 16'(k), 16'(3 * T));
    chk("disarm_armed", 16'(armed), 16'h0000);
    // disarm wins when all three controls land together, idle or running
    pulse(1'b1, 1'b1, 1'b1, 8'h03);
    repeat (3) @(negedge clk);
    chk("prio", 16'(armed), 16'h0000);
    pulse(1'b1, 1'b0, 1'b0, 8'h02);
    pulse(1'b1, 1'b1, 1'b1, 8'h01);
    wait_fire(3 * T, k);
    chk("prio_run_quiet", 16'(k), 16'(3 * T));
    chk("prio_run", 16'(armed), 16'h0000);
    // reset in mid count drops the countdown with no system reset
    pulse(1'b1, 1'b0, 1'b0, 8'h02);
    repeat (T) @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("mid_rst", 16'({armed, sys_reset, seconds_left}), 16'h0000);
    rst_n = 1'b1;
    wait_fire(3 * T, k);
    chk("mid_rst_quiet", 16'(k), 16'(3 * T));
    chk("mid_rst_armed", 16'(armed), 16'h0000);
    results();
  end
endmodule
`default_nettype wire
